// ===== core/brwp_pkg.sv
`default_nettype none
package brwp_pkg;
    // boot window, byte addresses
    localparam logic [31:0] WIN_LO = 32'h1c00_0000;
    localparam logic [31:0] WIN_HI = 32'h1fff_ffff;
    localparam logic [31:0] WIN_END = 32'h2000_0000;
    localparam logic [31:0] SIZE_MIN_BYTES = 32'h0008_0000;
    localparam logic [31:0] HW_BASE_SMALL = 32'h1fc0_0000;
    localparam logic [2:0] SIZE_CODE_4MB = 3'h3;
    localparam int BLOCK_SHIFT = 16;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 32;

    // strap field positions on the multiplexed address bus
    localparam int STRAP_SIZE_LSB = 0;
    localparam int STRAP_HWP_LSB = 3;
    localparam int STRAP_FR_BIT = 8;
    localparam int STRAP_W = 9;

    // strap values held until the first capture
    localparam logic [2:0] SIZE_RST = 3'h0;
    localparam logic [3:0] HWP_RST = 4'hf;
    localparam logic [3:0] HWP_OFF = 4'hf;

    // write-protect register layout
    localparam logic [31:0] WP_RST = 32'hffff_ff7f;
    localparam int WP_VAL_LSB = 0;
    localparam int WP_VAL_W = 7;
    localparam int WP_KEY_LSB = 8;
    localparam int WP_KEY_W = 24;
    localparam logic [23:0] WP_KEY_OVERRIDE = 24'hc0de_99;
    localparam logic [23:0] WP_KEY_ONES = 24'hff_ffff;
    localparam logic [6:0] WP_VAL_OFF = 7'h7f;

    // access sizes and rom widths share one code: 0 byte, 1 half, 2 word
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    // chip select time per rom cycle, least time rounds up
    localparam int CLK_PERIOD_NS = 50;
    localparam int ROM_ACCESS_NS = 200;
    localparam int ROM_ACC_CYC = (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] ROM_ACC_LAST = 4'(ROM_ACC_CYC - 1);

    typedef enum logic [1:0] {
        BRWP_IDLE,
        BRWP_ACCESS,
        BRWP_GAP,
        BRWP_RESP
    } brwp_state_t;
endpackage
`default_nettype wire

// ===== core/brwp_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface brwp_cfg_if;
    logic strap_valid;
    logic [2:0] size_code;
    logic [3:0] hw_count;
    logic fault_recovery;
    logic hw_override;
    logic [6:0] sw_count;

    modport cfg (output strap_valid, size_code, hw_count, fault_recovery, hw_override, sw_count);
    modport dec (input strap_valid, size_code, hw_count, fault_recovery, hw_override, sw_count);
endinterface
`default_nettype wire

// ===== core/brwp_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module brwp_cfg (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [brwp_pkg::STRAP_W-1:0] i_strap,
    input wire logic i_wp_write,
    input wire logic [31:0] i_wp_wdata,
    output logic [31:0] o_wp_rdata,
    brwp_cfg_if.cfg cfg
);
    logic seen_reg;
    logic [2:0] size_reg;
    logic [3:0] hwp_reg;
    logic fr_reg;
    logic [23:0] key_reg;
    logic [6:0] sw_protect_block_count_reg;

    // straps are caught on the first edge after release, while the bus is not driven
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            seen_reg <= 1'b0;
            size_reg <= brwp_pkg::SIZE_RST;
            hwp_reg <= brwp_pkg::HWP_RST;
            fr_reg <= 1'b0;
        end else if (!seen_reg) begin
            seen_reg <= 1'b1;
            size_reg <= i_strap[brwp_pkg::STRAP_SIZE_LSB +: 3];
            hwp_reg <= i_strap[brwp_pkg::STRAP_HWP_LSB +: 4];
            fr_reg <= i_strap[brwp_pkg::STRAP_FR_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            key_reg <= brwp_pkg::WP_RST[brwp_pkg::WP_KEY_LSB +: brwp_pkg::WP_KEY_W];
            sw_protect_block_count_reg <= brwp_pkg::WP_RST[brwp_pkg::WP_VAL_LSB +: brwp_pkg::WP_VAL_W];
        end else if (i_wp_write) begin
            sw_protect_block_count_reg <= i_wp_wdata[brwp_pkg::WP_VAL_LSB +: brwp_pkg::WP_VAL_W];
            if (i_wp_wdata[brwp_pkg::WP_KEY_LSB +: brwp_pkg::WP_KEY_W] == brwp_pkg::WP_KEY_OVERRIDE) begin
                key_reg <= brwp_pkg::WP_KEY_OVERRIDE;
            end else begin
                key_reg <= brwp_pkg::WP_KEY_ONES;
            end
        end
    end

    // bit 7 reads as zero
    assign o_wp_rdata = {key_reg, 1'b0, sw_protect_block_count_reg};
    assign cfg.strap_valid = seen_reg;
    assign cfg.size_code = size_reg;
    assign cfg.hw_count = hwp_reg;
    assign cfg.fault_recovery = fr_reg;
    assign cfg.hw_override = (key_reg == brwp_pkg::WP_KEY_OVERRIDE);
    assign cfg.sw_count = sw_protect_block_count_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_key_readback: assert property (i_wp_write && i_wp_wdata[31:8] != brwp_pkg::WP_KEY_OVERRIDE
        |=> o_wp_rdata[31:8] == brwp_pkg::WP_KEY_ONES && !cfg.hw_override)
        else $error("key field not all ones after non-override write");
    a_strap_hold: assert property (seen_reg |=> $stable(size_reg) && $stable(hwp_reg) && $stable(fr_reg))
        else $error("strap values changed after capture");
endmodule
`default_nettype wire

// ===== core/brwp_decode.sv
`timescale 1ns/1ps
`default_nettype none
module brwp_decode (
    input wire logic [31:0] i_addr,
    brwp_cfg_if.dec cfg,
    output logic o_in_window,
    output logic o_in_range,
    output logic o_protected
);
    logic [31:0] size_bytes;
    logic [31:0] rom_base;
    logic [31:0] prot_base;
    logic [31:0] hw_len;
    logic [31:0] sw_len;
    logic [31:0] prot_len;
    logic [31:0] offset;
    logic [31:0] rom_off;

    always_comb begin
        size_bytes = brwp_pkg::SIZE_MIN_BYTES << cfg.size_code;
        // roms up to 4 MB all start at the small base and end at or below the window top
        rom_base = (cfg.size_code <= brwp_pkg::SIZE_CODE_4MB) ? brwp_pkg::HW_BASE_SMALL
            : (brwp_pkg::WIN_END - size_bytes);
        rom_off = i_addr - rom_base;
        // small roms keep their protected boot block at the top window start
        prot_base = (cfg.size_code <= brwp_pkg::SIZE_CODE_4MB) ? brwp_pkg::HW_BASE_SMALL : rom_base;
        // strap codes a count minus one; all ones or an override key means none
        if (cfg.hw_count == brwp_pkg::HWP_OFF || cfg.hw_override) begin
            hw_len = 32'h0;
        end else begin
            hw_len = ({28'h0, cfg.hw_count} + 32'h1) << brwp_pkg::BLOCK_SHIFT;
        end
        if (cfg.sw_count == brwp_pkg::WP_VAL_OFF) begin
            sw_len = 32'h0;
        end else begin
            sw_len = ({25'h0, cfg.sw_count} + 32'h1) << brwp_pkg::BLOCK_SHIFT;
        end
        // both ranges start at one base, so their union is the longer one
        prot_len = (hw_len > sw_len) ? hw_len : sw_len;
        offset = i_addr - prot_base;
        o_in_window = (i_addr >= brwp_pkg::WIN_LO) && (i_addr <= brwp_pkg::WIN_HI);
        o_in_range = o_in_window && (i_addr >= rom_base) && (rom_off < size_bytes);
        o_protected = (i_addr >= prot_base) && (offset < prot_len);
    end
endmodule
`default_nettype wire

// ===== core/brwp_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - serve 8/16/32-bit boot rom in window 0x1c00_0000 to 0x1fff_ffff.
// - no bursts; each access is one address and data cycle.
// - pci-side masters get no path to the boot rom.
// - drive a full 26-bit byte address during every rom access.
// - latch size straps at reset release; 000 is 0.5 MB, 111 is 64 MB.
// - word, halfword and byte reads and writes over the 32-bit data bus.
// - word read from byte rom is four byte cycles packed into one word.
// - rom chip select low for every access inside the boot window; driven only for in-range rom cycles, slot 2 select under fault recovery.
// - writes assert the memory write strobe with chip select.
// - reads assert byte-enable strobe and output enable with chip select.
// - in-window access beyond rom size returns zero with data-error bit.
// - out-of-range access sets bus error status; interrupt only if enabled.
// - sample four-bit hardware protection strap at reset release.
// - strap is block count minus one; 1111 disables hardware protection.
// - protection base 0x1fc0_0000 up to 4 MB, else the rom base.
// - seven-bit software value protects up to 127 more 64-KB blocks.
// - software range starts at the hardware protection base.
// - protected region is the union of hardware and software ranges.
// - boot window may map onto slot 2 holding 85-ns flash.
// - fault-recovery strap high at release maps boot window to slot 2.
// - override key in upper field suspends hardware protection.
// - any other key restores hardware protection; key reads all ones.
// - writes inside the protected range terminate without writing.
module brwp_top (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req_valid,
    input wire logic i_req_from_pci,
    input wire logic i_req_write,
    input wire logic [1:0] i_req_size,
    input wire logic [31:0] i_req_addr,
    input wire logic [31:0] i_req_wdata,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [31:0] o_rsp_rdata,
    output logic o_cpu_command_bus_err,
    output logic o_rsp_write_blocked,
    input wire logic [1:0] i_rom_width,
    input wire logic i_wp_write,
    input wire logic [31:0] i_wp_wdata,
    output logic [31:0] o_wp_rdata,
    input wire logic i_bus_err_clear,
    input wire logic i_bus_err_int_en,
    output logic o_bus_err_status,
    output logic o_int_n,
    output logic o_fault_recovery,
    input wire logic [brwp_pkg::ADDR_W-1:0] i_mem_mux_addr_bus,
    output logic [brwp_pkg::ADDR_W-1:0] o_mem_mux_addr_bus,
    output logic o_mem_mux_addr_bus_oe,
    output logic o_rom_chip_select_n,
    output logic o_slot2_chip_select_n,
    output logic o_mem_write_strobe_n,
    output logic o_byte_enable_strobe_n,
    output logic o_rom_output_enable_n,
    input wire logic [brwp_pkg::DATA_W-1:0] i_mem_data_bus,
    output logic [brwp_pkg::DATA_W-1:0] o_mem_data_bus,
    output logic o_mem_data_bus_oe
);
    brwp_cfg_if cfg_bus ();

    brwp_pkg::brwp_state_t state_reg;
    logic [3:0] cyc_reg;
    logic [1:0] beat_reg;
    logic [1:0] beats_m1_reg;
    logic [1:0] width_reg;
    logic write_reg;
    logic [31:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic err_reg;
    logic blocked_reg;
    logic bus_err_reg;
    logic [25:0] mux_addr_reg;
    logic [31:0] data_out_reg;
    logic in_window;
    logic in_range;
    logic prot_hit;
    logic take;
    logic cycle_end;
    logic [1:0] beats_m1_next;
    logic [31:0] lane_mask;
    logic [4:0] lane_shift;
    logic [25:0] beat_addr;
    logic in_window_hold;

    brwp_cfg u_cfg (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_strap(i_mem_mux_addr_bus[brwp_pkg::STRAP_W-1:0]),
        .i_wp_write(i_wp_write),
        .i_wp_wdata(i_wp_wdata),
        .o_wp_rdata(o_wp_rdata),
        .cfg(cfg_bus.cfg)
    );

    brwp_decode u_decode (
        .i_addr(i_req_addr),
        .cfg(cfg_bus.dec),
        .o_in_window(in_window),
        .o_in_range(in_range),
        .o_protected(prot_hit)
    );

    // no request is taken until the straps have been caught
    assign o_req_ready = (state_reg == brwp_pkg::BRWP_IDLE) && cfg_bus.strap_valid;
    assign take = i_req_valid && o_req_ready;
    assign cycle_end = (state_reg == brwp_pkg::BRWP_ACCESS) && (cyc_reg == brwp_pkg::ROM_ACC_LAST);

    // a wide access on a narrow rom is split into one rom cycle per rom width
    always_comb begin
        if (i_req_size > i_rom_width) begin
            beats_m1_next = 2'((3'h1 << (i_req_size - i_rom_width)) - 3'h1);
        end else begin
            beats_m1_next = 2'h0;
        end
    end

    always_comb begin
        case (width_reg)
            brwp_pkg::SZ_BYTE: lane_mask = 32'h0000_00ff;
            brwp_pkg::SZ_HALF: lane_mask = 32'h0000_ffff;
            default: lane_mask = 32'hffff_ffff;
        endcase
        lane_shift = 5'({beat_reg, 3'h0} << width_reg);
        beat_addr = addr_reg[25:0] + 26'({beat_reg} << width_reg);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg <= brwp_pkg::BRWP_IDLE;
        end else begin
            case (state_reg)
                brwp_pkg::BRWP_IDLE: begin
                    if (take) begin
                        // refused requests answer at once and never touch the pins
                        if (i_req_from_pci || !in_range || (i_req_write && prot_hit)) begin
                            state_reg <= brwp_pkg::BRWP_RESP;
                        end else begin
                            state_reg <= brwp_pkg::BRWP_ACCESS;
                        end
                    end
                end
                brwp_pkg::BRWP_ACCESS: begin
                    if (cycle_end) begin
                        state_reg <= (beat_reg == beats_m1_reg) ? brwp_pkg::BRWP_RESP : brwp_pkg::BRWP_GAP;
                    end
                end
                brwp_pkg::BRWP_GAP: state_reg <= brwp_pkg::BRWP_ACCESS;
                brwp_pkg::BRWP_RESP: state_reg <= brwp_pkg::BRWP_IDLE;
                default: state_reg <= brwp_pkg::BRWP_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cyc_reg <= 4'h0;
        end else if (state_reg == brwp_pkg::BRWP_ACCESS && !cycle_end) begin
            cyc_reg <= cyc_reg + 4'h1;
        end else begin
            cyc_reg <= 4'h0;
        end
    end

    // one address per rom cycle, never a burst
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            beat_reg <= 2'h0;
        end else if (take) begin
            beat_reg <= 2'h0;
        end else if (cycle_end && beat_reg != beats_m1_reg) begin
            beat_reg <= beat_reg + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            beats_m1_reg <= 2'h0;
            width_reg <= brwp_pkg::SZ_WORD;
            write_reg <= 1'b0;
            addr_reg <= 32'h0;
            wdata_reg <= 32'h0;
            err_reg <= 1'b0;
            blocked_reg <= 1'b0;
        end else if (take) begin
            beats_m1_reg <= beats_m1_next;
            width_reg <= i_rom_width;
            write_reg <= i_req_write;
            addr_reg <= i_req_addr;
            wdata_reg <= i_req_wdata;
            err_reg <= i_req_from_pci || !in_range;
            blocked_reg <= i_req_write && prot_hit && in_range && !i_req_from_pci;
        end
    end

    // narrow reads are packed low lane first
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_reg <= 32'h0;
        end else if (take) begin
            rdata_reg <= 32'h0;
        end else if (cycle_end && !write_reg) begin
            rdata_reg <= rdata_reg | ((i_mem_data_bus & lane_mask) << lane_shift);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mux_addr_reg <= 26'h0;
            data_out_reg <= 32'h0;
        end else if (take) begin
            // load at take so the first access cycle already shows the new address
            mux_addr_reg <= i_req_addr[25:0];
            data_out_reg <= i_req_wdata;
        end else if (state_reg != brwp_pkg::BRWP_IDLE) begin
            mux_addr_reg <= beat_addr;
            data_out_reg <= (wdata_reg >> lane_shift) & lane_mask;
        end
    end

    // a fresh fault wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            bus_err_reg <= 1'b0;
        end else if (take && in_window && !in_range && !i_req_from_pci) begin
            bus_err_reg <= 1'b1;
        end else if (i_bus_err_clear) begin
            bus_err_reg <= 1'b0;
        end
    end

    logic pins_active;
    logic strobe_on;
    logic fr_map;
    assign pins_active = (state_reg == brwp_pkg::BRWP_ACCESS) || (state_reg == brwp_pkg::BRWP_GAP);
    // strobes are held off for the first cycle so the address settles first
    assign strobe_on = (state_reg == brwp_pkg::BRWP_ACCESS) && (cyc_reg != 4'h0);
    assign fr_map = cfg_bus.fault_recovery;

    assign o_mem_mux_addr_bus = mux_addr_reg;
    assign o_mem_mux_addr_bus_oe = pins_active;
    assign o_rom_chip_select_n = !(state_reg == brwp_pkg::BRWP_ACCESS && !fr_map);
    assign o_slot2_chip_select_n = !(state_reg == brwp_pkg::BRWP_ACCESS && fr_map);
    // a protected write never reaches this state, so the strobe stays high
    assign o_mem_write_strobe_n = !(strobe_on && write_reg);
    assign o_byte_enable_strobe_n = !(strobe_on && !write_reg);
    assign o_rom_output_enable_n = !(strobe_on && !write_reg);
    assign o_mem_data_bus = data_out_reg;
    assign o_mem_data_bus_oe = pins_active && write_reg;

    assign o_rsp_valid = (state_reg == brwp_pkg::BRWP_RESP);
    assign o_rsp_rdata = (err_reg || write_reg) ? 32'h0 : rdata_reg;
    assign o_cpu_command_bus_err = o_rsp_valid && err_reg;
    assign o_rsp_write_blocked = o_rsp_valid && blocked_reg;
    assign o_bus_err_status = bus_err_reg;
    assign o_int_n = !(bus_err_reg && i_bus_err_int_en);
    assign o_fault_recovery = fr_map;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    localparam int ACC_MAX = 20;

    sequence s_byte_access;
        !o_rom_chip_select_n [*4] ##1 o_rom_chip_select_n;
    endsequence
    sequence s_four_byte_cycles;
        s_byte_access ##1 s_byte_access ##1 s_byte_access ##1 s_byte_access;
    endsequence

    a_cs_in_window: assert property (!o_rom_chip_select_n |-> in_window_hold)
        else $error("chip select outside boot window");
    a_write_strobe_cs: assert property (!o_mem_write_strobe_n |-> !(o_rom_chip_select_n && o_slot2_chip_select_n)
        && o_rom_output_enable_n)
        else $error("write strobe without chip select");
    a_read_strobes: assert property (!o_rom_output_enable_n |-> !o_byte_enable_strobe_n
        && !(o_rom_chip_select_n && o_slot2_chip_select_n))
        else $error("read strobes not paired with chip select");
    a_pci_refused: assert property (take && i_req_from_pci |=> o_rsp_valid && o_cpu_command_bus_err
        && o_rom_chip_select_n)
        else $error("pci request reached the rom");
    a_range_error: assert property (take && in_window && !in_range && !i_req_from_pci
        |=> o_rsp_valid && o_cpu_command_bus_err && o_rsp_rdata == 32'h0 && o_bus_err_status)
        else $error("out-of-range access not answered with error");
    a_prot_write: assert property (take && i_req_write && prot_hit && in_range && !i_req_from_pci
        |=> o_rsp_valid && o_rsp_write_blocked ##1 o_mem_write_strobe_n)
        else $error("protected write was not terminated");
    a_int_gate: assert property (o_bus_err_status && !i_bus_err_int_en |-> o_int_n)
        else $error("interrupt raised while disabled");
    a_byte_word: assert property (take && !i_req_from_pci && in_range && !i_req_write
        && i_req_size == brwp_pkg::SZ_WORD && i_rom_width == brwp_pkg::SZ_BYTE
        |=> s_four_byte_cycles ##0 o_rsp_valid)
        else $error("byte rom word read not four cycles");
    a_rsp_bound: assert property (take |-> ##[1:ACC_MAX] o_rsp_valid)
        else $error("access did not finish in time");
    a_addr_width: assert property (!o_rom_chip_select_n |-> o_mem_mux_addr_bus_oe
        && o_mem_mux_addr_bus == beat_addr)
        else $error("rom address not driven");

    assign in_window_hold = (addr_reg >= brwp_pkg::WIN_LO) && (addr_reg <= brwp_pkg::WIN_HI);
endmodule
`default_nettype wire

// ===== sim/brwp_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module brwp_rom_model (
    input wire logic i_clk,
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [25:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata,
    output logic [31:0] o_last_write
);
    logic [31:0] last_reg = 32'h0;
    logic [7:0] a;
    assign a = i_addr[7:0];
    always_ff @(posedge i_clk) begin
        last_reg <= o_rdata;
    end
    // a released bus shows the inverse of its last value, so a stale sample never matches
    assign o_rdata = (!i_cs_n && !i_oe_n) ? {a, a ^ 8'h11, a ^ 8'h22, a ^ 8'h3c} : ~last_reg;
    always_ff @(posedge i_clk) begin
        if (!i_cs_n && !i_we_n) begin
            o_last_write <= i_wdata;
        end
    end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic req_valid = 1'b0, from_pci = 1'b0, req_write = 1'b0, wp_write = 1'b0, err_clear = 1'b0, int_en = 1'b0;
    logic [1:0] req_size = 2'h2, rom_width = 2'h2;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, wp_wdata = 32'h0;
    logic [8:0] strap_reg = 9'h0;
    logic req_ready, rsp_valid, rsp_err, rsp_blk, err_status, int_n, fault_rec;
    logic addr_oe, rom_cs_n, slot_cs_n, we_n, bbe_n, oe_n, data_oe;
    logic [31:0] rsp_rdata, wp_rdata, data_out, rom_rdata, rom_written, data_pin;
    logic [25:0] addr_out, addr_pin;
    logic cs_q = 1'b1, we_q = 1'b1, slot_q = 1'b1;
    int n_mismatch = 0;
    int checked = 0;
    int n_beats = 0, n_we = 0, n_slot = 0;
    int rb;
    // straps stay on the pins whenever the block is not driving them
    assign addr_pin = addr_oe ? addr_out : {17'h0, strap_reg};
    assign data_pin = data_oe ? data_out : rom_rdata;
    brwp_top u_brwp_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(req_valid), .i_req_from_pci(from_pci),
        .i_req_write(req_write), .i_req_size(req_size), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
        .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata), .o_cpu_command_bus_err(rsp_err),
        .o_rsp_write_blocked(rsp_blk), .i_rom_width(rom_width), .i_wp_write(wp_write), .i_wp_wdata(wp_wdata),
        .o_wp_rdata(wp_rdata), .i_bus_err_clear(err_clear), .i_bus_err_int_en(int_en), .o_bus_err_status(err_status),
        .o_int_n(int_n), .o_fault_recovery(fault_rec), .i_mem_mux_addr_bus(addr_pin), .o_mem_mux_addr_bus(addr_out),
        .o_mem_mux_addr_bus_oe(addr_oe), .o_rom_chip_select_n(rom_cs_n), .o_slot2_chip_select_n(slot_cs_n),
        .o_mem_write_strobe_n(we_n), .o_byte_enable_strobe_n(bbe_n), .o_rom_output_enable_n(oe_n),
        .i_mem_data_bus(data_pin), .o_mem_data_bus(data_out), .o_mem_data_bus_oe(data_oe));
    brwp_rom_model u_brwp_rom_model (.i_clk(i_clk), .i_cs_n(rom_cs_n & slot_cs_n), .i_oe_n(oe_n | bbe_n),
        .i_we_n(we_n), .i_addr(addr_out), .i_wdata(data_out), .o_rdata(rom_rdata), .o_last_write(rom_written));
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cs_q <= rom_cs_n;
        we_q <= we_n;
        slot_q <= slot_cs_n;
        if (cs_q && !rom_cs_n) n_beats++;
        if (slot_q && !slot_cs_n) n_slot++;
        if (we_q && !we_n) n_we++;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [8:0] s);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        strap_reg <= s;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        check("wp reset", wp_rdata, 32'hffff_ff7f);
        check("int idle", 32'(int_n), 32'h1);
    endtask
    task automatic wp(input logic [31:0] v, input logic [31:0] exp);
        @(posedge i_clk);
        wp_write <= 1'b1;
        wp_wdata <= v;
        @(posedge i_clk);
        wp_write <= 1'b0;
        @(negedge i_clk);
        check("wp read", wp_rdata, exp);
    endtask
    // a request is held from one rising edge to the next, where ready is known high in idle
    task automatic access(input string name, input logic pci, input logic wr, input logic [1:0] sz, input logic [1:0] w,
        input logic [31:0] addr, input logic [31:0] d, input logic e_err, input logic e_blk, input int e_lat,
        input int e_beats);
        int lat;
        int b0;
        int w0;
        lat = 0;
        b0 = n_beats + n_slot;
        w0 = n_we;
        while (req_ready !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        req_valid <= 1'b1;
        from_pci <= pci;
        req_write <= wr;
        req_size <= sz;
        rom_width <= w;
        req_addr <= addr;
        req_wdata <= d;
        @(posedge i_clk);
        req_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && lat < 40) begin
            @(negedge i_clk);
            lat++;
        end
        check({name, " latency"}, 32'(lat), 32'(e_lat));
        check({name, " data"}, rsp_rdata, wr ? 32'h0 : d);
        check({name, " error"}, 32'(rsp_err), 32'(e_err));
        check({name, " blocked"}, 32'(rsp_blk), 32'(e_blk));
        @(negedge i_clk);
        check({name, " beats"}, 32'(n_beats + n_slot - b0), 32'(e_beats));
        check({name, " strobes"}, 32'(n_we - w0), (wr && !e_blk && !e_err) ? 32'(e_beats) : 32'h0);
        $display("test %s done", name);
    endtask
    initial begin
        // 1 MB rom, one hardware block, standard space
        do_reset(9'h001);
        access("word32", 0, 0, brwp_pkg::SZ_WORD, 2'h2, 32'h1fc1_0000, 32'h0011_223c, 0, 0, 5, 1);
        access("word8", 0, 0, brwp_pkg::SZ_WORD, 2'h0, 32'h1fc1_0004, 32'h3b3a_3938, 0, 0, 20, 4);
        access("word16", 0, 0, brwp_pkg::SZ_WORD, 2'h1, 32'h1fc1_0008, 32'h2836_2a34, 0, 0, 10, 2);
        access("byte wr", 0, 1, brwp_pkg::SZ_BYTE, 2'h0, 32'h1fc2_0000, 32'h0000_00a5, 0, 0, 5, 1);
        check("rom written", rom_written & 32'hff, 32'h0000_00a5);
        @(posedge i_clk);
        int_en <= 1'b1;
        access("beyond", 0, 0, brwp_pkg::SZ_WORD, 2'h2, 32'h1fd0_0000, 32'h0, 1, 0, 1, 0);
        check("err status", 32'(err_status), 32'h1);
        check("int raised", 32'(int_n), 32'h0);
        @(posedge i_clk);
        int_en <= 1'b0;
        @(negedge i_clk);
        check("int masked", 32'(int_n), 32'h1);
        @(posedge i_clk);
        err_clear <= 1'b1;
        @(posedge i_clk);
        err_clear <= 1'b0;
        @(negedge i_clk);
        check("err cleared", 32'(err_status), 32'h0);
        access("pci", 1, 0, brwp_pkg::SZ_WORD, 2'h2, 32'h1fc1_0000, 32'h0, 1, 0, 1, 0);
        check("pci status", 32'(err_status), 32'h0);
        access("outside", 0, 0, brwp_pkg::SZ_WORD, 2'h2, 32'h2000_0000, 32'h0, 1, 0, 1, 0);
        access("hw block", 0, 1, brwp_pkg::SZ_WORD, 2'h2, 32'h1fc0_0004, 32'h1234_5678, 0, 1, 1, 0);
        wp(32'hc0de_99ff, 32'hc0de_997f);
        access("override", 0, 1, brwp_pkg::SZ_WORD, 2'h2, 32'h1fc0_0004, 32'h1234_5678, 0, 0, 5, 1);
        wp(32'h1234_5602, 32'hffff_ff02);
        access("sw block", 0, 1, brwp_pkg::SZ_WORD, 2'h2, 32'h1fc2_fffc, 32'h5555_aaaa, 0, 1, 1, 0);
        access("sw edge", 0, 1, brwp_pkg::SZ_WORD, 2'h2, 32'h1fc3_0000, 32'h5555_aaaa, 0, 0, 5, 1);
        // 64 MB rom, two hardware blocks, fault recovery in slot 2
        do_reset(9'h10f);
        @(negedge i_clk);
        check("fault rec", 32'(fault_rec), 32'h1);
        rb = n_beats;
        access("slot2 rd", 0, 0, brwp_pkg::SZ_WORD, 2'h2, 32'h1c00_0000, 32'h0011_223c, 0, 0, 5, 1);
        check("rom cs idle", 32'(n_beats - rb), 32'h0);
        access("hw64 blk", 0, 1, brwp_pkg::SZ_WORD, 2'h2, 32'h1c01_fffc, 32'h0f0f_f0f0, 0, 1, 1, 0);
        access("hw64 ok", 0, 1, brwp_pkg::SZ_WORD, 2'h2, 32'h1c02_0000, 32'h0f0f_f0f0, 0, 0, 5, 1);
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
